//--- interval_timer.sv
`timescale 1ns/1ps
`include "interval_timer_defines.svh"

// Notes on behaviour
// - Chip select high blocks access, bus floats
// - Chip select never stops counting
// - Byte-wide three-state port for all traffic
// - Read strobe drives selected counter byte
// - Write strobe stores control or count byte
// - Address picks counter; read of 11 floats
// - Write at address 11 stores control word
// - Control word has no read path
// - Each counter is 16-bit presettable down counter
// - Three counters keep independent state
// - Control word selects one counter; 11 illegal
// - Format picks low, high or both bytes
// - Format 00 latches count, keeps format
// - Mode bits decode modes 0 to 5
// - Low bit picks binary or decimal counting
// - State undefined until counter programmed; reset here zeroes it
// - Load completes after clock rise then fall
// - Count readable while running via latch
// - Zero count acts as maximum count
module interval_timer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire interval_timer_pkg::hostBus_t hostBus,
    output logic [7:0] dataOut,
    output logic dataOe,
    input wire logic [2:0] countClk,
    input wire logic [2:0] gate,
    output logic [2:0] timerOut
);
    import interval_timer_pkg::*;

    typedef struct packed {
        logic [`SYNC_WIDTH-1:0] s1;
        logic [`SYNC_WIDTH-1:0] s2;
        logic [`SYNC_WIDTH-1:0] s3;
        logic [`SYNC_WIDTH-1:0] flt;
        busPhase_t phase;
        logic [1:0] addr;
        logic [7:0] data;
        logic [7:0] dataOut;
        logic dataOe;
        chan_t [2:0] ch;
    } state_t;

    state_t state_reg;
    state_t state_next;
    hostBus_t busF;
    logic [2:0] clkF;
    logic [2:0] gateF;

    ////////////////////////////////////////////////////////////////////
    // Down-count by one, binary or four decades
    function automatic logic [15:0] decCount(input logic [15:0] v,
                                             input logic bcd);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (borrow) begin
                    if (r[4*k +: 4] == 4'h0) begin
                        r[4*k +: 4] = 4'h9;
                    end else begin
                        r[4*k +: 4] = r[4*k +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    // Top bit ignored for modes 2 and 3
    function automatic logic [2:0] modeDecode(input logic [2:0] m);
        return m[1] ? {1'b0, m[1:0]} : m;
    endfunction

    // Byte of a counter that a read returns
    function automatic logic [7:0] readByte(input chan_t c);
        logic [15:0] src;
        src = c.holdValid ? c.hold : c.cnt;
        if (c.fmt == `FMT_HIGH || (c.fmt == `FMT_BOTH && c.rdHi)) begin
            return src[15:8];
        end
        return src[7:0];
    endfunction

    assign busF = state_reg.flt[12:0];
    assign gateF = state_reg.flt[15:13];
    assign clkF = state_reg.flt[18:16];
    assign dataOut = state_reg.dataOut;
    assign dataOe = state_reg.dataOe;
    assign timerOut = {state_reg.ch[2].out, state_reg.ch[1].out,
                       state_reg.ch[0].out};

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [7:0] wd;
        logic [1:0] sel;
        logic rise;
        logic fall;
        logic [15:0] d;
        logic [15:0] step;
        wd = state_reg.data;
        sel = wd[`CW_SEL_HI:`CW_SEL_LO];
        rise = 1'b0;
        fall = 1'b0;
        d = 16'h0000;
        step = 16'h0000;
        state_next = state_reg;
        state_next.s1 = {countClk, gate, hostBus};
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        state_next.flt = (state_reg.s2 & state_reg.s3) |
            (state_reg.flt & (state_reg.s2 ^ state_reg.s3));

        unique case (state_reg.phase)
            PH_IDLE: begin
                state_next.dataOe = 1'b0;
                state_next.addr = busF.addr;
                if (!busF.csN && !busF.wrN) begin
                    state_next.phase = PH_WRITE;
                end else if (!busF.csN && !busF.rdN) begin
                    state_next.phase = PH_READ;
                end
            end
            PH_READ: begin
                // address 11 read leaves the bus floating
                if (busF.csN || busF.rdN) begin
                    state_next.dataOe = 1'b0;
                    state_next.phase = PH_IDLE;
                    for (int i = 0; i < 3; i++) begin
                        if (state_reg.addr == 2'(i)) begin
                            if (state_reg.ch[i].fmt == `FMT_BOTH &&
                                !state_reg.ch[i].rdHi) begin
                                state_next.ch[i].rdHi = 1'b1;
                            end else begin
                                state_next.ch[i].rdHi = 1'b0;
                                state_next.ch[i].holdValid = 1'b0;
                            end
                        end
                    end
                end else begin
                    state_next.addr = busF.addr;
                    state_next.dataOe = 1'b0;
                    for (int i = 0; i < 3; i++) begin
                        if (busF.addr == 2'(i)) begin
                            state_next.dataOut = readByte(state_reg.ch[i]);
                            state_next.dataOe = 1'b1;
                        end
                    end
                end
            end
            PH_WRITE: begin
                if (busF.wrN) begin
                    state_next.phase = PH_IDLE;
                    // control word goes only to the counter state
                    if (state_reg.addr == `ADDR_CONTROL &&
                        sel != `SEL_ILLEGAL) begin
                        for (int i = 0; i < 3; i++) begin
                            if (sel == 2'(i)) begin
                                if (wd[`CW_FMT_HI:`CW_FMT_LO] == `FMT_LATCH)
                                begin
                                    if (!state_reg.ch[i].holdValid) begin
                                        state_next.ch[i].hold =
                                            state_reg.ch[i].cnt;
                                        state_next.ch[i].holdValid = 1'b1;
                                    end
                                end else begin
                                    state_next.ch[i].mode = modeDecode(
                                        wd[`CW_MODE_HI:`CW_MODE_LO]);
                                    state_next.ch[i].bcd = wd[`CW_BCD];
                                    state_next.ch[i].fmt =
                                        wd[`CW_FMT_HI:`CW_FMT_LO];
                                    state_next.ch[i].wrHi = 1'b0;
                                    state_next.ch[i].rdHi = 1'b0;
                                    state_next.ch[i].holdValid = 1'b0;
                                    state_next.ch[i].loadPend = 1'b0;
                                    state_next.ch[i].loadRise = 1'b0;
                                    state_next.ch[i].running = 1'b0;
                                    state_next.ch[i].trig = 1'b0;
                                    state_next.ch[i].out = modeDecode(
                                        wd[`CW_MODE_HI:`CW_MODE_LO]) !=
                                        `MODE_RESET;
                                end
                            end
                        end
                    end
                    // count byte into the addressed counter
                    for (int i = 0; i < 3; i++) begin
                        if (state_reg.addr == 2'(i)) begin
                            unique case (state_reg.ch[i].fmt)
                                `FMT_LOW: begin
                                    state_next.ch[i].reload = {8'h00, wd};
                                    state_next.ch[i].loadPend = 1'b1;
                                end
                                `FMT_HIGH: begin
                                    state_next.ch[i].reload = {wd, 8'h00};
                                    state_next.ch[i].loadPend = 1'b1;
                                end
                                `FMT_BOTH: begin
                                    if (!state_reg.ch[i].wrHi) begin
                                        state_next.ch[i].reload[7:0] = wd;
                                        state_next.ch[i].wrHi = 1'b1;
                                        if (state_reg.ch[i].mode == 3'h0) begin
                                            state_next.ch[i].running = 1'b0;
                                        end
                                    end else begin
                                        state_next.ch[i].reload[15:8] = wd;
                                        state_next.ch[i].wrHi = 1'b0;
                                        state_next.ch[i].loadPend = 1'b1;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end else begin
                    state_next.addr = busF.addr;
                    state_next.data = busF.data;
                end
            end
            default: begin
                state_next.phase = PH_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////
        // counters never look at chip select
        // each channel works from its own state
        for (int i = 0; i < 3; i++) begin
            rise = clkF[i] && !state_reg.ch[i].clkPrev;
            fall = !clkF[i] && state_reg.ch[i].clkPrev;
            state_next.ch[i].clkPrev = clkF[i];
            state_next.ch[i].gatePrev = gateF[i];
            if (gateF[i] && !state_reg.ch[i].gatePrev &&
                state_reg.ch[i].mode != 3'h0 && state_reg.ch[i].mode != 3'h4)
            begin
                state_next.ch[i].trig = 1'b1;
            end
            if ((state_reg.ch[i].mode == 3'h2 ||
                 state_reg.ch[i].mode == 3'h3) && !gateF[i]) begin
                state_next.ch[i].out = 1'b1;
            end
            // pending load needs a rising then a falling edge
            if (state_reg.ch[i].loadPend && rise) begin
                state_next.ch[i].loadRise = 1'b1;
            end
            if (state_reg.ch[i].loadRise && fall) begin
                state_next.ch[i].cnt = state_reg.ch[i].reload;
                state_next.ch[i].loadPend = 1'b0;
                state_next.ch[i].loadRise = 1'b0;
                state_next.ch[i].running = 1'b1;
                if (state_reg.ch[i].mode == 3'h0) begin
                    state_next.ch[i].out = 1'b0;
                end
            end else if (fall && state_reg.ch[i].running) begin
                // down count; zero wraps to the maximum
                d = decCount(state_reg.ch[i].cnt, state_reg.ch[i].bcd);
                unique case (state_reg.ch[i].mode)
                    3'h0, 3'h4: begin
                        if (gateF[i]) begin
                            state_next.ch[i].cnt = d;
                            if (state_reg.ch[i].mode == 3'h0) begin
                                state_next.ch[i].out =
                                    state_reg.ch[i].out || d == 16'h0000;
                            end else begin
                                state_next.ch[i].out = d != 16'h0000;
                            end
                        end
                    end
                    3'h1, 3'h5: begin
                        if (state_reg.ch[i].trig) begin
                            state_next.ch[i].cnt = state_reg.ch[i].reload;
                            state_next.ch[i].trig = 1'b0;
                            state_next.ch[i].out =
                                state_reg.ch[i].mode != 3'h1;
                        end else begin
                            state_next.ch[i].cnt = d;
                            if (state_reg.ch[i].mode == 3'h1) begin
                                state_next.ch[i].out =
                                    state_reg.ch[i].out || d == 16'h0000;
                            end else begin
                                state_next.ch[i].out = d != 16'h0000;
                            end
                        end
                    end
                    3'h2: begin
                        if (state_reg.ch[i].trig) begin
                            state_next.ch[i].cnt = state_reg.ch[i].reload;
                            state_next.ch[i].trig = 1'b0;
                        end else if (gateF[i]) begin
                            if (state_reg.ch[i].cnt == 16'h0001) begin
                                state_next.ch[i].cnt = state_reg.ch[i].reload;
                                state_next.ch[i].out = 1'b1;
                            end else begin
                                state_next.ch[i].cnt = d;
                                state_next.ch[i].out = d != 16'h0001;
                            end
                        end
                    end
                    3'h3: begin
                        step = !state_reg.ch[i].cnt[0] ? 16'h0002 :
                            (state_reg.ch[i].out ? 16'h0001 : 16'h0003);
                        if (state_reg.ch[i].trig) begin
                            state_next.ch[i].cnt = state_reg.ch[i].reload;
                            state_next.ch[i].trig = 1'b0;
                        end else if (gateF[i]) begin
                            if (state_reg.ch[i].cnt != 16'h0000 &&
                                state_reg.ch[i].cnt <= step) begin
                                state_next.ch[i].cnt = state_reg.ch[i].reload;
                                state_next.ch[i].out = !state_reg.ch[i].out;
                            end else begin
                                state_next.ch[i].cnt = decCount(
                                    state_reg.ch[i].cnt, state_reg.ch[i].bcd);
                                if (step != 16'h0001) begin
                                    state_next.ch[i].cnt = decCount(
                                        state_next.ch[i].cnt,
                                        state_reg.ch[i].bcd);
                                end
                                if (step == 16'h0003) begin
                                    state_next.ch[i].cnt = decCount(
                                        state_next.ch[i].cnt,
                                        state_reg.ch[i].bcd);
                                end
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.s1 <= `SYNC_IDLE;
            state_reg.s2 <= `SYNC_IDLE;
            state_reg.s3 <= `SYNC_IDLE;
            state_reg.flt <= `SYNC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cbSys @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_read_needs_select: assert property (
        dataOe |-> !$past(busF.csN) && !$past(busF.rdN))
        else $error("read data driven without select");

    chk_idle_when_off: assert property (
        state_reg.phase == PH_IDLE && busF.csN |=>
            state_reg.phase == PH_IDLE)
        else $error("access started while deselected");

    chk_ctrl_unreadable: assert property (
        dataOe |-> state_reg.addr != `ADDR_CONTROL)
        else $error("bus driven for the control address");

    chk_illegal_select: assert property (
        state_reg.phase == PH_WRITE && busF.wrN &&
            state_reg.addr == `ADDR_CONTROL &&
            state_reg.data[`CW_SEL_HI:`CW_SEL_LO] == `SEL_ILLEGAL |=>
            $stable(state_reg.ch[0].fmt) && $stable(state_reg.ch[1].fmt) &&
            $stable(state_reg.ch[2].fmt))
        else $error("illegal select reprogrammed a counter");

    chk_latch_snapshot: assert property (
        $rose(state_reg.ch[0].holdValid) |->
            $stable(state_reg.ch[0].fmt) &&
            state_reg.ch[0].hold == $past(state_reg.ch[0].cnt))
        else $error("latch changed format or missed the count");

    generate
        for (genvar g = 0; g < 3; g++) begin : gChk
            chk_count_on_fall: assert property (
                $changed(state_reg.ch[g].cnt) |->
                    $past(state_reg.ch[g].clkPrev) && !$past(clkF[g]))
                else $error("count changed without a clock fall");
            chk_load_on_fall: assert property (
                $rose(state_reg.ch[g].running) |->
                    $past(state_reg.ch[g].clkPrev) && !$past(clkF[g]))
                else $error("load completed without a clock fall");
        end
    endgenerate

    cov_read_answered: cover property (
        state_reg.phase == PH_READ && dataOe);
    cov_latch_taken: cover property ($rose(state_reg.ch[0].holdValid));
    cov_terminal_count: cover property ($rose(state_reg.ch[1].out));
    cov_rate_pulse: cover property (
        state_reg.ch[2].mode == 3'h2 && $fell(state_reg.ch[2].out));
endmodule

//--- interval_timer_defines.svh
`ifndef INTERVAL_TIMER_DEFINES_SVH
`define INTERVAL_TIMER_DEFINES_SVH

// Port addresses on the two select inputs
`define ADDR_COUNTER0 2'h0
`define ADDR_COUNTER1 2'h1
`define ADDR_COUNTER2 2'h2
`define ADDR_CONTROL 2'h3

// Control word field positions
`define CW_SEL_HI 7
`define CW_SEL_LO 6
`define CW_FMT_HI 5
`define CW_FMT_LO 4
`define CW_MODE_HI 3
`define CW_MODE_LO 1
`define CW_BCD 0

// Byte access formats
`define FMT_LATCH 2'h0
`define FMT_LOW 2'h1
`define FMT_HIGH 2'h2
`define FMT_BOTH 2'h3
`define SEL_ILLEGAL 2'h3

// Reset values
`define COUNT_RESET 16'h0000
`define MODE_RESET 3'h0

// Pin inputs: chip select, two host strobes and address/data plus clock and gate
`define SYNC_WIDTH 19
// Idle pin levels: select and strobes high
`define SYNC_IDLE 19'h01C00

`endif

//--- interval_timer_pkg.sv
package interval_timer_pkg;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_READ = 2'b01,
        PH_WRITE = 2'b10
    } busPhase_t;

    typedef struct packed {
        logic csN;
        logic rdN;
        logic wrN;
        logic [1:0] addr;
        logic [7:0] data;
    } hostBus_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] reload;
        logic [15:0] hold;
        logic holdValid;
        logic [2:0] mode;
        logic bcd;
        logic [1:0] fmt;
        logic wrHi;
        logic rdHi;
        logic loadPend;
        logic loadRise;
        logic running;
        logic trig;
        logic out;
        logic gatePrev;
        logic clkPrev;
    } chan_t;

endpackage

//--- host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic sys_clk,
    output interval_timer_pkg::hostBus_t hostBus,
    input wire logic [7:0] dataOut,
    input wire logic dataOe
);
    import interval_timer_pkg::*;

    initial begin
        hostBus.csN = 1'b1;
        hostBus.rdN = 1'b1;
        hostBus.wrN = 1'b1;
        hostBus.addr = 2'h0;
        hostBus.data = 8'h00;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Chip select goes high; address and data lines show the inverse of their last value
    task automatic release_bus(input logic [1:0] a, input logic [7:0] d);
        hostBus.csN <= 1'b1;
        hostBus.addr <= ~a;
        hostBus.data <= ~d;
        cyc(5);
    endtask

    // caller supplies bytes in programmed order
    // select field comes from the caller unchanged
    task automatic write_port(input logic [1:0] a, input logic [7:0] d,
                              input logic cs);
        hostBus.addr <= a;
        hostBus.data <= d;
        hostBus.csN <= cs;
        cyc(1);
        hostBus.wrN <= 1'b0;
        cyc(8);
        hostBus.wrN <= 1'b1;
        cyc(5);
        release_bus(a, d);
    endtask

    // read is taken well after the answer has settled
    task automatic read_port(input logic [1:0] a, input logic cs,
                             output logic [7:0] d, output logic oe);
        hostBus.addr <= a;
        hostBus.csN <= cs;
        cyc(1);
        hostBus.rdN <= 1'b0;
        cyc(10);
        d = dataOut;
        oe = dataOe;
        hostBus.rdN <= 1'b1;
        cyc(6);
        release_bus(a, hostBus.data);
    endtask
endmodule

//--- interval_timer_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); \
        end \
    end

module interval_timer_tb_top;
    import interval_timer_pkg::*;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    hostBus_t hostDrv;
    hostBus_t busPin;
    logic [7:0] dataOut;
    logic dataOe;
    logic [2:0] countClk = 3'h0;
    logic [2:0] gate = 3'h0;
    logic [2:0] timerOut;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #10 sys_clk = ~sys_clk;

    // Data pin level from both drivers
    always_comb begin
        busPin = hostDrv;
        if (dataOe === 1'b1) begin
            busPin.data = dataOut;
        end
    end

    host_cpu_model u_host_cpu_model (
        .sys_clk(sys_clk),
        .hostBus(hostDrv),
        .dataOut(dataOut),
        .dataOe(dataOe)
    );

    interval_timer u_interval_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .hostBus(busPin),
        .dataOut(dataOut),
        .dataOe(dataOe),
        .countClk(countClk),
        .gate(gate),
        .timerOut(timerOut)
    );

    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("[ERR] %0t run did not finish", $time);
            give_verdict();
        end
    end

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        u_host_cpu_model.write_port(a, d, 1'b0);
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic cs,
                          input logic expOe, input logic [7:0] expD);
        logic [7:0] d;
        logic oe;
        u_host_cpu_model.read_port(a, cs, d, oe);
        `CHK(oe, expOe)
        if (expOe) begin
            `CHK(d, expD)
        end
    endtask

    // Count clock pulses, 8 system clocks per phase
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            countClk[ch] <= 1'b1;
            repeat (8) @(posedge sys_clk);
            countClk[ch] <= 1'b0;
            repeat (8) @(posedge sys_clk);
        end
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        `CHK(dataOe, 1'b0)
        wr(2'h3, 8'h30);
        wr(2'h0, 8'h34);
        wr(2'h0, 8'h12);
        pulse(0, 1);
        `CHK(timerOut[0], 1'b0)
        rd_chk(2'h0, 1'b0, 1'b1, 8'h34);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h12);
        u_host_cpu_model.write_port(2'h0, 8'hEE, 1'b1);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h34);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h12);
        rd_chk(2'h3, 1'b0, 1'b0, 8'h00);
        rd_chk(2'h0, 1'b1, 1'b0, 8'h00);
        wr(2'h3, 8'h50);
        wr(2'h1, 8'h07);
        wr(2'h3, 8'hA0);
        wr(2'h2, 8'h56);
        pulse(1, 1);
        pulse(2, 1);
        rd_chk(2'h1, 1'b0, 1'b1, 8'h07);
        rd_chk(2'h2, 1'b0, 1'b1, 8'h56);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h34);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h12);
        gate[0] <= 1'b1;
        pulse(0, 3);
        wr(2'h3, 8'h00);
        pulse(0, 2);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h31);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h12);
        gate[0] <= 1'b0;
        rd_chk(2'h0, 1'b0, 1'b1, 8'h2F);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h12);
        wr(2'h3, 8'hD0);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h2F);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h12);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h2F);
        wr(2'h3, 8'h30);
        wr(2'h0, 8'h78);
        wr(2'h0, 8'h56);
        pulse(0, 1);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h78);
        rd_chk(2'h0, 1'b0, 1'b1, 8'h56);
        wr(2'h3, 8'h51);
        wr(2'h1, 8'h00);
        pulse(1, 1);
        gate[1] <= 1'b1;
        pulse(1, 1);
        rd_chk(2'h1, 1'b0, 1'b1, 8'h99);
        wr(2'h3, 8'h50);
        wr(2'h1, 8'h02);
        pulse(1, 1);
        `CHK(timerOut[1], 1'b0)
        pulse(1, 2);
        `CHK(timerOut[1], 1'b1)
        wr(2'h3, 8'hA0);
        wr(2'h2, 8'h00);
        pulse(2, 1);
        gate[2] <= 1'b1;
        pulse(2, 1);
        rd_chk(2'h2, 1'b0, 1'b1, 8'hFF);
        for (int m = 0; m < 8; m++) begin
            wr(2'h3, {2'h2, 2'h3, 3'(m), 1'b0});
            repeat (8) @(posedge sys_clk);
            `CHK(timerOut[2], (m != 0))
        end
        // Mode code 110 must act as mode 2
        wr(2'h3, 8'h9C);
        wr(2'h2, 8'h03);
        pulse(2, 1);
        `CHK(timerOut[2], 1'b1)
        pulse(2, 2);
        `CHK(timerOut[2], 1'b0)
        give_verdict();
    end
endmodule
